// *** core/servo_system_command_handler.sv ***
// Operation
// - 0x71 with zero payload queries power
// - Power reply is unsigned 16-bit, 0.1 W
// - Power reply: echo, zeros, low byte 6
// - 0x76 resets system, sends no reply
// - 0x77 releases the holding brake
// - 0x78 engages the holding brake
// - Brake commands reply with exact echo
// - Brake output defaults to engaged state
// - 0xB1 queries millisecond run time
// - Uptime reply: echo, zeros, bytes 4-7 LSB-first
// - Uptime counter restarts at zero on reset
module servo_system_command_handler #(
    parameter int CYCLES_PER_MS = sys_cmd_pkg::CYCLES_PER_MS
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire logic [63:0] cmd_data_i,
    input wire logic [15:0] motor_power_i,
    output logic reply_valid_o,
    output logic [63:0] reply_data_o,
    output logic brake_engaged_o,
    output logic sys_reset_o,
    output logic cmd_ignored_o
);
    import sys_cmd_pkg::*;

    // Byte view of the incoming frame, byte 0 in bits 7:0
    logic [7:0] cmd_byte [FRAME_BYTES];
    // Payload bytes 1..7 must be zero for any of these commands
    logic payload_zero;
    logic [7:0] opcode;
    logic [31:0] uptime_ms_count_q;
    logic [$clog2(CYCLES_PER_MS)-1:0] ms_div_q;
    logic [$clog2(RESET_PULSE_CYCLES+1)-1:0] rst_cnt_q;
    // Soft reset request, held for a few cycles so it is seen system-wide
    logic soft_reset;

    // One lane per byte of the frame; transport framing, ids and CRC are
    // stripped before the frame reaches this block
    genvar gi;
    generate
        for (gi = 0; gi < FRAME_BYTES; gi++) begin : g_bytes
            assign cmd_byte[gi] = cmd_data_i[gi*8 +: 8];
        end
    endgenerate

    assign opcode = cmd_byte[0];
    assign payload_zero = (cmd_data_i[63:8] == 56'h0);
    assign soft_reset = (rst_cnt_q != '0);

    // Reset pulse generator; the system restarts when this releases
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_cnt_q <= '0;
            sys_reset_o <= 1'b0;
        end else begin
            if (cmd_valid_i && payload_zero && opcode == CMD_SYS_RESET && !soft_reset) begin
                rst_cnt_q <= ($bits(rst_cnt_q))'(RESET_PULSE_CYCLES);
            end else if (soft_reset) begin
                rst_cnt_q <= rst_cnt_q - 1'b1;
            end
            sys_reset_o <= (cmd_valid_i && payload_zero && opcode == CMD_SYS_RESET)
                           || (rst_cnt_q > 1);
        end
    end

    // Millisecond divider and uptime counter; both start again at zero
    // on hard reset and during the soft reset pulse.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ms_div_q <= '0;
            uptime_ms_count_q <= 32'h0;
        end else if (soft_reset) begin
            ms_div_q <= '0;
            uptime_ms_count_q <= 32'h0;
        end else if (ms_div_q == ($bits(ms_div_q))'(CYCLES_PER_MS - 1)) begin
            ms_div_q <= '0;
            // Wraps after 2^32 ms, about 49 days
            uptime_ms_count_q <= uptime_ms_count_q + 32'h1;
        end else begin
            ms_div_q <= ms_div_q + 1'b1;
        end
    end

    // Holding brake: locked out of reset so an unpowered or restarting
    // drive never lets the motor move.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            brake_engaged_o <= BRAKE_ENGAGED;
        end else if (soft_reset) begin
            brake_engaged_o <= BRAKE_ENGAGED;
        end else if (cmd_valid_i && payload_zero) begin
            case (opcode)
                CMD_BRAKE_RELEASE: brake_engaged_o <= BRAKE_RELEASED;
                CMD_BRAKE_ENGAGE: brake_engaged_o <= BRAKE_ENGAGED;
                default: brake_engaged_o <= brake_engaged_o;
            endcase
        end
    end

    // Reply builder: one cycle after the command frame
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reply_valid_o <= 1'b0;
            reply_data_o <= 64'h0;
            cmd_ignored_o <= 1'b0;
        end else begin
            reply_valid_o <= 1'b0;
            cmd_ignored_o <= 1'b0;
            if (cmd_valid_i && !soft_reset) begin
                if (!payload_zero) begin
                    // Malformed frames get no reply and are flagged on cmd_ignored_o
                    cmd_ignored_o <= 1'b1;
                end else begin
                    case (opcode)
                        CMD_POWER_QUERY: begin
                            reply_valid_o <= 1'b1;
                            reply_data_o <= {motor_power_i, 40'h0, opcode};
                        end
                        CMD_BRAKE_RELEASE, CMD_BRAKE_ENGAGE: begin
                            reply_valid_o <= 1'b1;
                            reply_data_o <= cmd_data_i;
                        end
                        CMD_UPTIME_QUERY: begin
                            reply_valid_o <= 1'b1;
                            reply_data_o <= {uptime_ms_count_q, 24'h0, opcode};
                        end
                        CMD_SYS_RESET: begin
                            reply_valid_o <= 1'b0;
                        end
                        default: begin
                            // Other codes belong to other handlers
                            cmd_ignored_o <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end
endmodule

// *** include/sys_cmd_pkg.sv ***
package sys_cmd_pkg;
    // Command codes in data byte 0
    localparam logic [7:0] CMD_POWER_QUERY = 8'h71;
    localparam logic [7:0] CMD_SYS_RESET = 8'h76;
    localparam logic [7:0] CMD_BRAKE_RELEASE = 8'h77;
    localparam logic [7:0] CMD_BRAKE_ENGAGE = 8'h78;
    localparam logic [7:0] CMD_UPTIME_QUERY = 8'hb1;
    // Frame identifiers
    localparam logic [10:0] CAN_REQ_ID = 11'h141;
    localparam logic [10:0] CAN_REPLY_ID = 11'h241;
    localparam logic [7:0] RS485_HEADER = 8'h3e;
    localparam logic [7:0] RS485_MOTOR_ID = 8'h01;
    localparam logic [7:0] FRAME_LEN = 8'h08;
    localparam int FRAME_BYTES = 8;
    // Field positions in the reply frame, byte indices
    localparam int POWER_LO_BYTE = 6;
    localparam int UPTIME_LO_BYTE = 4;
    // Brake output: high means engaged (locked)
    localparam logic BRAKE_ENGAGED = 1'b1;
    localparam logic BRAKE_RELEASED = 1'b0;
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_MS = 1;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;
    localparam int RESET_PULSE_CYCLES = 4;
endpackage

// *** verification/sys_cmd_properties.sv ***
module sys_cmd_properties (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire logic [63:0] cmd_data_i,
    input wire logic [15:0] motor_power_i,
    input wire logic reply_valid_o,
    input wire logic [63:0] reply_data_o,
    input wire logic brake_engaged_o,
    input wire logic sys_reset_o,
    input wire logic cmd_ignored_o
);
    // Frames arriving during a soft reset get no answer, so they are left out
    wire go = cmd_valid_i && !sys_reset_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    AST_PWR: assert property (go && cmd_data_i == 64'h71 |=> reply_valid_o &&
        reply_data_o == {$past(motor_power_i), 40'h0, 8'h71}) else $error("power reply");
    AST_SRST: assert property (go && cmd_data_i == 64'h76 |=> !reply_valid_o &&
        sys_reset_o [*4] ##1 !sys_reset_o) else $error("soft reset");
    AST_REL: assert property (go && cmd_data_i == 64'h77 |=> !brake_engaged_o &&
        reply_valid_o && reply_data_o == 64'h77) else $error("brake release");
    AST_ENG: assert property (go && cmd_data_i == 64'h78 |=> brake_engaged_o &&
        reply_valid_o && reply_data_o == 64'h78) else $error("brake engage");
    AST_UPT: assert property (go && cmd_data_i == 64'hb1 |=> reply_valid_o &&
        reply_data_o[31:0] == 32'hb1) else $error("uptime reply");
    AST_BRK_PWRUP: assert property ($rose(resetn_i) |-> brake_engaged_o) else $error("brake");
    AST_BRK_SOFT: assert property (sys_reset_o |=> brake_engaged_o) else $error("brake soft");
    AST_IGN: assert property (go && cmd_data_i[63:8] != 56'h0 |=> cmd_ignored_o &&
        !reply_valid_o) else $error("payload not refused");
    AST_QUIET: assert property (!cmd_valid_i |=> !reply_valid_o) else $error("stray reply");
endmodule
bind servo_system_command_handler sys_cmd_properties sys_cmd_properties_inst (.*);

// *** verification/host_model.sv ***
module host_model (
    input wire logic clk_i,
    output logic cmd_valid_o,
    output logic [63:0] cmd_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_data_o = 64'h0;
    end
    // One frame per call; released data is inverted so stale bytes never look valid
    task automatic send(input logic [63:0] f);
        @(posedge clk_i) #5;
        cmd_valid_o = 1'b1;
        cmd_data_o = f;
        @(posedge clk_i) #5;
        cmd_valid_o = 1'b0;
        cmd_data_o = ~f;
    endtask
endmodule

// *** verification/testbench.sv ***
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sys_cmd_pkg::*;
    logic clk_sys_i = 0, resetn_i = 0, cmd_valid, rv, brk, srst, ign;
    logic [63:0] cmd_data, rd;
    logic [31:0] up;
    logic [15:0] pwr = 16'h07d0; // 200 W in tenths
    int num_errors = 0, checks = 0, cyc = 0;
    host_model host_inst (.clk_i(clk_sys_i), .cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data));
    servo_system_command_handler #(.CYCLES_PER_MS(10)) servo_system_command_handler_inst (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid),
        .cmd_data_i(cmd_data), .motor_power_i(pwr), .reply_valid_o(rv), .reply_data_o(rd),
        .brake_engaged_o(brk), .sys_reset_o(srst), .cmd_ignored_o(ign));
    initial forever #25 clk_sys_i = ~clk_sys_i;
    // Hang guard, far above the roughly 130 cycles the scenarios need
    always @(posedge clk_sys_i) if (++cyc > 5000) begin
        num_errors++;
        conclude();
    end
    task conclude;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task t_power;
        host_inst.send({56'h0, CMD_POWER_QUERY});
        `CHK("pwr", {pwr, 40'h0, 8'h71}, rd)
        `CHK("pwr_v", 1'b1, rv)
        host_inst.send({56'h0, 8'h70});
        `CHK("unk", 2'b10, {ign, rv})
    endtask
    task t_brake;
        `CHK("brk_pwrup", 1'b1, brk)
        host_inst.send({8'h01, 48'h0, CMD_BRAKE_RELEASE});
        `CHK("ign", 1'b1, ign)
        `CHK("brk_kept", 1'b1, brk)
        host_inst.send({56'h0, CMD_BRAKE_RELEASE});
        `CHK("rel", {1'b0, 64'h77}, {brk, rd})
        host_inst.send({56'h0, CMD_BRAKE_ENGAGE});
        `CHK("eng", {1'b1, 64'h78}, {brk, rd})
    endtask
    task t_uptime;
        host_inst.send({56'h0, CMD_UPTIME_QUERY});
        up = rd[63:32];
        repeat (98) @(posedge clk_sys_i);
        host_inst.send({56'h0, CMD_UPTIME_QUERY});
        `CHK("upt", {up + 32'h0a, 32'hb1}, rd)
    endtask
    task t_soft;
        host_inst.send({56'h0, CMD_BRAKE_RELEASE});
        host_inst.send({56'h0, CMD_SYS_RESET});
        `CHK("srst", 3'b010, {rv, srst, brk})
        repeat (4) @(posedge clk_sys_i);
        #5 `CHK("srst_end", 1'b0, srst)
        `CHK("brk_soft", 1'b1, brk)
        host_inst.send({56'h0, CMD_UPTIME_QUERY});
        `CHK("upt0", {32'h0, 32'hb1}, rd)
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        #5 resetn_i = 1'b1;
        t_brake();
        t_power();
        t_uptime();
        t_soft();
        conclude();
    end
endmodule
